// >>> design/ccs_pkg.sv
// Overview of operation
// - top two bits of event register ignore writes and read back as one-zero
// - answer timeout flag sets when card clock counter overflows before io edge
// - reading event register clears flags five to two; writing zero never clears
// - host may set over-current flag; then no deactivation and no interrupt
// - host may set supply-range flag; this starts card deactivation
// - presence flag sets on filtered presence change and on low pin after reset
// - over-current flag sets when supply monitor reports excess current
// - supply-range flag sets when card supply leaves selected voltage window
// - supply level 00 off, 01 1.8 V, 10 3 V, 11 5 V; resets 00
// - nonzero level with card present starts converter; zero level stops it
// - no deactivation between nonzero levels; host deactivates before changing
// - auto timing drives reset pin from sequencer, else pin follows control bit
// - power-down bit deactivates card; supply level writable only while clear
// - polarity set: low pin means no card; clear: high pin means no card
// - changing detect polarity sets presence flag
// - presence pull-up follows pull-up enable bit, which resets to one
// - presence filter run 0,4,8..256 samples by code; code resets to 2
// - code zero, pin select zero: irq pin high without card, low with card
// - code zero, pin select one, clock stopped: irq pin ignores card changes
// - deactivate on hardware over-current, supply-range, or card removal
// - deactivation steps of 8 converter clocks: reset, clock 5, io 6, level 7
package ccs_pkg;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;  // arbitrary bus address
  localparam logic REG_EVT = 1'h0;
  localparam logic REG_DET = 1'h1;
  localparam logic [1:0] EVT_TOP = 2'h2;
  localparam logic [1:0] LVL_RST = 2'h0;
  localparam logic [6:0] DET_RST = 7'h0a;
  localparam int TMO_BIT = 5;
  localparam int PRS_BIT = 4;
  localparam int OVC_BIT = 3;
  localparam int RNG_BIT = 2;
  localparam int AUTO_RST_BIT = 6;
  localparam int SHD_BIT = 5;
  localparam int POL_BIT = 4;
  localparam int PUP_BIT = 3;
  localparam int STEP_PERIODS = 8;
  localparam int CLK_STOP_STEP = 5;
  localparam int IO_OFF_STEP = 6;
  localparam int LVL_OFF_STEP = 7;
  localparam int POR_WAIT = 3;
  typedef enum logic [2:0] {TW_IDLE, TW_ADDR, TW_AACK, TW_WR, TW_WACK, TW_RD, TW_RACK} ccs_twi_t;
  typedef enum logic {DS_IDLE, DS_RUN} ccs_deact_t;
endpackage

// >>> design/ccs_det_filter.sv
`timescale 1ns/1ns
module ccs_det_filter (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic [2:0] code_i,
  output logic level_o
);
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic lvl_nxt;
  logic [9:0] thr;

  // =====================================
  // run length
  always_comb begin
    thr = (code_i == 3'h0) ? 10'h0 : (10'h2 << code_i);
    cnt_nxt = 9'h0;
    lvl_nxt = level_o;
    if (pin_i != level_o) begin
      if ({1'b0, cnt_r} + 10'h1 >= thr) begin
        lvl_nxt = pin_i;
      end else begin
        cnt_nxt = cnt_r + 9'h1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 9'h0;
      level_o <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      level_o <= lvl_nxt;
    end
  end
endmodule

// >>> design/ccs_twi_slave.sv
`timescale 1ns/1ns
module ccs_twi_slave #(
  parameter logic [6:0] DEV_ADDR = ccs_pkg::DEV_ADDR_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic wr_stb_o,
  output logic wr_ptr_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o,
  output logic [7:0] rd_byte_o,
  input wire logic [7:0] rd_data_i
);
  logic [1:0] scl_q, sda_q;
  logic scl_d, sda_d, rise, fall, start, stop;
  ccs_pkg::ccs_twi_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_nxt, wd_nxt;
  logic rw_r, rw_nxt, first_r, first_nxt, nack_r, nack_nxt, oe_nxt;
  logic ws_nxt, wp_nxt, rs_nxt;

  // =====================================
  // line events
  assign rise = scl_q[1] & ~scl_d;
  assign fall = ~scl_q[1] & scl_d;
  assign start = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  assign stop = scl_q[1] & scl_d & ~sda_d & sda_q[1];

  // =====================================
  // byte engine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = rd_byte_o;
    rw_nxt = rw_r;
    first_nxt = first_r;
    nack_nxt = nack_r;
    oe_nxt = sda_oe_o;
    ws_nxt = 1'b0;
    wp_nxt = wr_ptr_o;
    wd_nxt = wr_data_o;
    rs_nxt = 1'b0;
    if (stop) begin
      st_nxt = ccs_pkg::TW_IDLE;
      oe_nxt = 1'b0;
    end else if (start) begin
      st_nxt = ccs_pkg::TW_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      first_nxt = 1'b1;
    end else begin
      case (st_r)
        ccs_pkg::TW_ADDR, ccs_pkg::TW_WR: begin
          if (rise) begin
            sh_nxt = {rd_byte_o[6:0], sda_q[1]};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            oe_nxt = 1'b1;
            if (st_r == ccs_pkg::TW_WR) begin
              ws_nxt = 1'b1;
              wp_nxt = first_r;
              wd_nxt = rd_byte_o;
              first_nxt = 1'b0;
              st_nxt = ccs_pkg::TW_WACK;
            end else if (rd_byte_o[7:1] == DEV_ADDR) begin
              rw_nxt = rd_byte_o[0];
              st_nxt = ccs_pkg::TW_AACK;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = ccs_pkg::TW_IDLE;
            end
          end
        end
        ccs_pkg::TW_WACK: begin
          if (fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt = ccs_pkg::TW_WR;
          end
        end
        ccs_pkg::TW_AACK, ccs_pkg::TW_RACK: begin
          if (rise) begin
            nack_nxt = sda_q[1] & (st_r == ccs_pkg::TW_RACK);
          end else if (fall) begin
            if (!rw_r) begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt = ccs_pkg::TW_WR;
            end else if (nack_r) begin
              oe_nxt = 1'b0;
              st_nxt = ccs_pkg::TW_IDLE;
            end else begin
              sh_nxt = rd_data_i;
              oe_nxt = ~rd_data_i[7];
              cnt_nxt = 4'h1;
              rs_nxt = 1'b1;
              st_nxt = ccs_pkg::TW_RD;
            end
          end
        end
        ccs_pkg::TW_RD: begin
          if (fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt = 1'b0;
              st_nxt = ccs_pkg::TW_RACK;
            end else begin
              oe_nxt = ~rd_byte_o[6];
              sh_nxt = {rd_byte_o[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      st_r <= ccs_pkg::TW_IDLE;
      cnt_r <= 4'h0;
      rd_byte_o <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_ptr_o <= 1'b0;
      wr_data_o <= 8'h00;
      rd_stb_o <= 1'b0;
    end else begin
      scl_q <= {scl_q[0], scl_i};
      sda_q <= {sda_q[0], sda_i};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_byte_o <= sh_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      nack_r <= nack_nxt;
      sda_o <= 1'b0;
      sda_oe_o <= oe_nxt;
      wr_stb_o <= ws_nxt;
      wr_ptr_o <= wp_nxt;
      wr_data_o <= wd_nxt;
      rd_stb_o <= rs_nxt;
    end
  end
endmodule

// >>> design/ccs_card_regs.sv
`timescale 1ns/1ns
module ccs_card_regs #(
  parameter logic [6:0] DEV_ADDR = ccs_pkg::DEV_ADDR_DEF,
  parameter int DCDC_DIV = 6
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic presence_pin_i,
  input wire logic overcurrent_i,
  input wire logic supply_fault_i,
  input wire logic answer_timeout_i,
  input wire logic card_reset_control_i,
  input wire logic auto_reset_level_i,
  input wire logic card_clk_req_i,
  input wire logic card_io_req_i,
  input wire logic irq_pin_select_i,
  output logic [1:0] supply_level_select_o,
  output logic dcdc_run_o,
  output logic card_reset_pin_o,
  output logic card_clk_run_o,
  output logic card_io_en_o,
  output logic presence_pullup_o,
  output logic power_down_o,
  output logic presence_irq_pin_o,
  output logic card_present_state_o
);
  localparam int STEP = ccs_pkg::STEP_PERIODS * DCDC_DIV;

  logic wr_stb, wr_ptr, rd_stb;
  logic [7:0] wr_data, rd_byte, rd_data;
  logic [2:0] snc1_r, snc2_r;
  logic ovc_d_r, rng_d_r, filt, present, ovc_hw, rng_hw;
  logic wr_evt, wr_det, rd_evt, pol_chg, por_hit;
  logic ptr_r, ptr_nxt;
  logic [3:0] evt_r, evt_nxt, set_v, clr_v;
  logic ovc_sw_r, ovc_sw_nxt;
  logic [1:0] lvl_nxt;
  logic [6:0] det_r, det_nxt;
  logic dcdc_nxt;
  logic [1:0] por_cnt_r, por_cnt_nxt;
  ccs_pkg::ccs_deact_t ds_r, ds_nxt;
  logic [8:0] ucnt_r, ucnt_nxt;
  logic [2:0] stp_r, stp_nxt;
  logic deact_go, rst_force_r, rst_force_nxt;
  logic clk_off_r, clk_off_nxt, io_off_r, io_off_nxt;
  logic irq_any, irq_nxt, pin_rst_nxt;

  // =====================================
  // host link
  ccs_twi_slave #(.DEV_ADDR(DEV_ADDR)) u_twi (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_stb_o(wr_stb),
    .wr_ptr_o(wr_ptr),
    .wr_data_o(wr_data),
    .rd_stb_o(rd_stb),
    .rd_byte_o(rd_byte),
    .rd_data_i(rd_data)
  );

  // read bit 7 of detect register is always zero, so a stray one is dropped
  assign rd_data = (ptr_r == ccs_pkg::REG_DET) ? {1'b0, det_r} :
      {ccs_pkg::EVT_TOP, evt_r, supply_level_select_o};
  assign wr_evt = wr_stb & ~wr_ptr & (ptr_r == ccs_pkg::REG_EVT);
  assign wr_det = wr_stb & ~wr_ptr & (ptr_r == ccs_pkg::REG_DET);
  assign rd_evt = rd_stb & (ptr_r == ccs_pkg::REG_EVT);

  // =====================================
  // presence path
  ccs_det_filter u_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(snc2_r[0]),
    .code_i(det_r[2:0]),
    .level_o(filt)
  );

  assign present = det_r[ccs_pkg::POL_BIT] ? filt : ~filt;
  assign ovc_hw = snc2_r[1] & ~ovc_d_r;
  assign rng_hw = snc2_r[2] & ~rng_d_r;
  assign pol_chg = wr_det & (wr_data[ccs_pkg::POL_BIT] != det_r[ccs_pkg::POL_BIT]);
  assign por_hit = (por_cnt_r == 2'(ccs_pkg::POR_WAIT - 1)) & ~snc2_r[0];

  // =====================================
  // flags
  always_comb begin
    set_v[3] = answer_timeout_i | (wr_evt & wr_data[ccs_pkg::TMO_BIT]);
    set_v[2] = (present != card_present_state_o) | pol_chg | por_hit
        | (wr_evt & wr_data[ccs_pkg::PRS_BIT]);
    set_v[1] = ovc_hw | (wr_evt & wr_data[ccs_pkg::OVC_BIT]);
    set_v[0] = rng_hw | (wr_evt & wr_data[ccs_pkg::RNG_BIT]);
    // only bits actually shipped to the host are cleared
    clr_v = rd_evt ? rd_byte[5:2] : 4'h0;
    evt_nxt = (evt_r & ~clr_v) | set_v;
    ovc_sw_nxt = ovc_sw_r;
    if (ovc_hw) begin
      ovc_sw_nxt = 1'b0;
    end else if (wr_evt & wr_data[ccs_pkg::OVC_BIT]) begin
      ovc_sw_nxt = 1'b1;
    end else if (clr_v[1]) begin
      ovc_sw_nxt = 1'b0;
    end
    por_cnt_nxt = por_cnt_r;
    if (por_cnt_r != 2'(ccs_pkg::POR_WAIT)) begin
      por_cnt_nxt = por_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      snc1_r <= 3'h1;
      snc2_r <= 3'h1;
      ovc_d_r <= 1'b0;
      rng_d_r <= 1'b0;
      evt_r <= 4'h0;
      ovc_sw_r <= 1'b0;
      por_cnt_r <= 2'h0;
      card_present_state_o <= 1'b0;
    end else begin
      snc1_r <= {supply_fault_i, overcurrent_i, presence_pin_i};
      snc2_r <= snc1_r;
      ovc_d_r <= snc2_r[1];
      rng_d_r <= snc2_r[2];
      evt_r <= evt_nxt;
      ovc_sw_r <= ovc_sw_nxt;
      por_cnt_r <= por_cnt_nxt;
      card_present_state_o <= present;
    end
  end

  // =====================================
  // configuration
  always_comb begin
    ptr_nxt = ptr_r;
    if (wr_stb & wr_ptr) begin
      ptr_nxt = wr_data[0];
    end
    det_nxt = det_r;
    if (wr_det) begin
      det_nxt = wr_data[6:0];
    end
    lvl_nxt = supply_level_select_o;
    dcdc_nxt = dcdc_run_o;
    if (wr_evt & ~det_r[ccs_pkg::SHD_BIT]) begin
      // 00 off, 01 1.8 V, 10 3 V, 11 5 V; nonzero swaps do not deactivate
      lvl_nxt = wr_data[1:0];
      if (wr_data[1:0] == 2'h0) begin
        dcdc_nxt = 1'b0;
      end else if (present) begin
        dcdc_nxt = 1'b1;
      end
    end
    if (ds_r == ccs_pkg::DS_RUN && stp_nxt == 3'(ccs_pkg::LVL_OFF_STEP)) begin
      lvl_nxt = 2'h0;
      dcdc_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_r <= ccs_pkg::REG_EVT;
      det_r <= ccs_pkg::DET_RST;
      supply_level_select_o <= ccs_pkg::LVL_RST;
      dcdc_run_o <= 1'b0;
    end else begin
      ptr_r <= ptr_nxt;
      det_r <= det_nxt;
      supply_level_select_o <= lvl_nxt;
      dcdc_run_o <= dcdc_nxt;
    end
  end

  // =====================================
  // deactivation sequencer
  // cannot be interrupted once started; new triggers while busy are dropped
  assign deact_go = ovc_hw | rng_hw | (wr_evt & wr_data[ccs_pkg::RNG_BIT])
      | (set_v[2] & ~present)
      | (wr_det & wr_data[ccs_pkg::SHD_BIT] & ~det_r[ccs_pkg::SHD_BIT]);

  always_comb begin
    ds_nxt = ds_r;
    ucnt_nxt = ucnt_r;
    stp_nxt = stp_r;
    rst_force_nxt = rst_force_r;
    clk_off_nxt = clk_off_r;
    io_off_nxt = io_off_r;
    if (wr_evt & ~det_r[ccs_pkg::SHD_BIT] & (wr_data[1:0] != 2'h0)) begin
      rst_force_nxt = 1'b0;
      clk_off_nxt = 1'b0;
      io_off_nxt = 1'b0;
    end
    case (ds_r)
      ccs_pkg::DS_IDLE: begin
        if (deact_go) begin
          ds_nxt = ccs_pkg::DS_RUN;
          ucnt_nxt = 9'h0;
          stp_nxt = 3'h0;
          rst_force_nxt = 1'b1;
        end
      end
      ccs_pkg::DS_RUN: begin
        ucnt_nxt = ucnt_r + 9'h1;
        if (ucnt_r == 9'(STEP - 1)) begin
          ucnt_nxt = 9'h0;
          stp_nxt = stp_r + 3'h1;
        end
        if (stp_nxt == 3'(ccs_pkg::CLK_STOP_STEP)) begin
          clk_off_nxt = 1'b1;
        end
        if (stp_nxt == 3'(ccs_pkg::IO_OFF_STEP)) begin
          io_off_nxt = 1'b1;
        end
        if (stp_nxt == 3'(ccs_pkg::LVL_OFF_STEP)) begin
          ds_nxt = ccs_pkg::DS_IDLE;
        end
      end
      default: begin
        ds_nxt = ccs_pkg::DS_IDLE;
      end
    endcase
  end

  // =====================================
  // pins
  always_comb begin
    pin_rst_nxt = 1'b0;
    if (!rst_force_r) begin
      pin_rst_nxt = det_r[ccs_pkg::AUTO_RST_BIT] ? auto_reset_level_i
          : card_reset_control_i;
    end
    // soft over-current stays quiet on the irq pin
    irq_any = evt_r[3] | evt_r[2] | evt_r[0] | (evt_r[1] & ~ovc_sw_r);
    // clock-stopped pass-through needs an unclocked path outside this logic
    irq_nxt = irq_pin_select_i ? ~irq_any : ~present;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ds_r <= ccs_pkg::DS_IDLE;
      ucnt_r <= 9'h0;
      stp_r <= 3'h0;
      rst_force_r <= 1'b1;
      clk_off_r <= 1'b1;
      io_off_r <= 1'b1;
      card_reset_pin_o <= 1'b0;
      card_clk_run_o <= 1'b0;
      card_io_en_o <= 1'b0;
      presence_pullup_o <= 1'b1;
      power_down_o <= 1'b0;
      presence_irq_pin_o <= 1'b1;
    end else begin
      ds_r <= ds_nxt;
      ucnt_r <= ucnt_nxt;
      stp_r <= stp_nxt;
      rst_force_r <= rst_force_nxt;
      clk_off_r <= clk_off_nxt;
      io_off_r <= io_off_nxt;
      card_reset_pin_o <= pin_rst_nxt;
      card_clk_run_o <= card_clk_req_i & ~clk_off_r;
      card_io_en_o <= card_io_req_i & ~io_off_r;
      presence_pullup_o <= det_r[ccs_pkg::PUP_BIT];
      power_down_o <= det_r[ccs_pkg::SHD_BIT];
      presence_irq_pin_o <= irq_nxt;
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  top_bits_a: assert property (rd_stb && !ptr_r |-> rd_byte[7:6] == 2'h2)
    else $error("event register top bits not one-zero");
  tmo_set_a: assert property (answer_timeout_i |=> evt_r[3])
    else $error("answer timeout flag not set");
  read_clear_a: assert property (rd_evt && rd_byte[3] && !set_v[1] |=> !evt_r[1])
    else $error("over-current flag survived clearing read");
  sw_ovc_quiet_a: assert property (wr_evt && wr_data[3] && !wr_data[2] && !ovc_hw && !rng_hw
      && present && ds_r == ccs_pkg::DS_IDLE |=> ds_r == ccs_pkg::DS_IDLE)
    else $error("soft over-current started deactivation");
  sw_rng_deact_a: assert property (wr_evt && wr_data[2] && ds_r == ccs_pkg::DS_IDLE
      |=> ds_r == ccs_pkg::DS_RUN ##1 !card_reset_pin_o)
    else $error("soft supply-range did not deactivate");
  prs_change_a: assert property (present != card_present_state_o |=> evt_r[2])
    else $error("presence change not flagged");
  lvl_off_a: assert property (ds_r == ccs_pkg::DS_RUN && stp_r == 3'h6 && ucnt_r == 9'(STEP - 1)
      |=> supply_level_select_o == 2'h0 && !dcdc_run_o && ds_r == ccs_pkg::DS_IDLE)
    else $error("supply level not zeroed at last step");
  rst_follow_a: assert property (!rst_force_r && !det_r[6]
      |=> card_reset_pin_o == $past(card_reset_control_i))
    else $error("reset pin not following control bit");
  shd_lock_a: assert property (det_r[5] && wr_evt && ds_r == ccs_pkg::DS_IDLE && !deact_go
      |=> supply_level_select_o == $past(supply_level_select_o))
    else $error("supply level changed during power-down");

  deact_done_c: cover property (ds_r == ccs_pkg::DS_RUN ##1 ds_r == ccs_pkg::DS_IDLE);
  prs_flag_c: cover property (present != card_present_state_o);
  evt_read_c: cover property (rd_evt && rd_byte[5:2] != 4'h0);
endmodule

// >>> bench/ccs_twi_host.sv
`timescale 1ns/1ns
module ccs_twi_host #(
  parameter logic [6:0] DEV_ADDR = ccs_pkg::DEV_ADDR_DEF
) (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ====================
  // bit level, 8 mclk per scl period, lines released when idle
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // data moves mid-low, far from both edges seen through the sync
  task automatic put_bit(input logic b);
    tick(2);
    sda_o = b;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    scl_o = 1'h0;
  endtask
  // sample late in high: device answers some 3 mclk after the fall
  task automatic get_bit(output logic b);
    tick(2);
    sda_o = 1'h1;
    tick(2);
    scl_o = 1'h1;
    tick(3);
    b = sda_i;
    tick(1);
    scl_o = 1'h0;
  endtask
  task automatic start_c();
    tick(2);
    sda_o = 1'h1;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_o = 1'h0;
    tick(4);
    scl_o = 1'h0;
  endtask
  task automatic stop_c();
    tick(2);
    sda_o = 1'h0;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_o = 1'h1;
    tick(4);
  endtask
  // ====================
  // byte level and transfers
  task automatic put_byte(input logic [7:0] d, output logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ok = (a === 1'h0);
  endtask
  // single byte reads only, so always end with a nack
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'h1);
  endtask
  task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] d,
                    output logic ok);
    logic [2:0] a;
    start_c();
    put_byte({addr, 1'h0}, a[0]);
    put_byte(ptr, a[1]);
    put_byte(ptr[0] ? {1'h0, d[6:0]} : d, a[2]);
    stop_c();
    ok = &a;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start_c();
    put_byte({DEV_ADDR, 1'h0}, a);
    put_byte(ptr, a);
    stop_c();
    start_c();
    put_byte({DEV_ADDR, 1'h1}, a);
    get_byte(d);
    stop_c();
  endtask
endmodule

// >>> bench/ccs_card_regs_tb.sv
`timescale 1ns/1ns
module ccs_card_regs_tb;
  logic mclk_i = 1'h0, rst_i = 1'h1, scl, h_sda, sda_w, d_sda, sda_oe;
  logic pres = 1'h1, ovc = 1'h0, sflt = 1'h0, tmo = 1'h0, sel = 1'h0;
  logic crc = 1'h1, arl = 1'h0;
  logic [1:0] sup;
  logic dcdc, clk_run, io_en, rst_pin, pup, pd, irq, present;
  logic [7:0] st;
  int checked = 0, n_mismatch = 0;
  assign st = {sup, dcdc, clk_run, io_en, rst_pin, pd, pup};
  assign sda_w = h_sda & ~(sda_oe & ~d_sda);
  always #20 mclk_i = ~mclk_i;
  // ====================
  // instances
  ccs_card_regs #(.DCDC_DIV(1)) u_ccs_card_regs (.mclk_i(mclk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_o(sda_oe),
    .presence_pin_i(pres), .overcurrent_i(ovc), .supply_fault_i(sflt),
    .answer_timeout_i(tmo), .card_reset_control_i(crc), .auto_reset_level_i(arl),
    .card_clk_req_i(1'h1), .card_io_req_i(1'h1), .irq_pin_select_i(sel),
    .supply_level_select_o(sup), .dcdc_run_o(dcdc), .card_reset_pin_o(rst_pin),
    .card_clk_run_o(clk_run), .card_io_en_o(io_en), .presence_pullup_o(pup),
    .power_down_o(pd), .presence_irq_pin_o(irq), .card_present_state_o(present));
  ccs_twi_host u_ccs_twi_host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(h_sda));
  // ====================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ok;
    u_ccs_twi_host.wr(ccs_pkg::DEV_ADDR_DEF, ptr, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    u_ccs_twi_host.rd(ptr, d);
    chk(d, exp);
  endtask
  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ====================
  // tests
  initial begin
    logic [1:0] sp;
    logic ok;
    tick(20);
    rst_i = 1'h0;
    tick(4);
    chk(st, 8'h01);
    rdc(8'h00, 8'h80);
    rdc(8'h01, 8'h0a);
    wr(8'h00, 8'hc0);
    rdc(8'h00, 8'h80);
    u_ccs_twi_host.wr(ccs_pkg::DEV_ADDR_DEF ^ 7'h01, 8'h00, 8'h03, ok);
    chk({7'h0, ok}, 8'h00);
    chk(st, 8'h01);
    tmo = 1'h1;
    tick(1);
    tmo = 1'h0;
    wr(8'h00, 8'h00);
    rdc(8'h00, 8'ha0);
    rdc(8'h00, 8'h80);
    $display("register test done");
    pres = 1'h0;
    tick(20);
    chk({6'h0, present, irq}, 8'h02);
    rdc(8'h00, 8'h90);
    // triggers: hw over-current, hw supply fault, sw supply flag, power-down
    for (int t = 0; t < 4; t++) begin
      sp = (t == 1) ? 2'h2 : 2'h1;
      wr(8'h00, {6'h0, sp});
      if (t == 0) begin
        wr(8'h00, 8'h03);
        sp = 2'h3;
        sel = 1'h1;
        wr(8'h00, 8'h0b);
        chk({7'h0, irq}, 8'h01);
        tmo = 1'h1;
        tick(1);
        tmo = 1'h0;
        tick(2);
        chk({7'h0, irq}, 8'h00);
        rdc(8'h00, 8'hab);
        sel = 1'h0;
      end
      tick(4);
      chk(st, {sp, 6'h3d});
      crc = 1'h0;
      tick(2);
      chk(st, {sp, 6'h39});
      if (t == 0) begin
        arl = 1'h1;
        wr(8'h01, 8'h4a);
        chk(st, {sp, 6'h3d});
        wr(8'h01, 8'h0a);
        arl = 1'h0;
      end
      crc = 1'h1;
      case (t)
        0: ovc = 1'h1;
        1: sflt = 1'h1;
        2: wr(8'h00, {6'h01, sp});
        default: wr(8'h01, 8'h2a);
      endcase
      if (t < 2) begin
        tick(38);
        chk(st, {sp, 6'h39});
        tick(8);
        chk(st, {sp, 6'h29});
        tick(8);
        chk(st, {sp, 6'h21});
      end
      tick(60);
      chk(st, (t == 3) ? 8'h03 : 8'h01);
      ovc = 1'h0;
      sflt = 1'h0;
      rdc(8'h00, (t == 0) ? 8'h88 : (t < 3) ? 8'h84 : 8'h80);
      if (t == 3) begin
        wr(8'h00, 8'h01);
        tick(4);
        chk(st, 8'h03);
        wr(8'h01, 8'h0a);
      end
    end
    $display("deactivation test done");
    for (int n = 0; n < 8; n++) begin
      wr(8'h01, {4'h0, ~n[0], n[2:0]});
      chk(st, {7'h0, ~n[0]});
      pres = ~pres;
      tick(2 << n);
      chk({6'h0, present, irq}, {6'h0, pres, ~pres});
      tick(8);
      chk({6'h0, present, irq}, {6'h0, ~pres, pres});
    end
    $display("filter test done");
    rdc(8'h00, 8'h90);
    wr(8'h01, 8'h1a);
    tick(20);
    chk({6'h0, present, irq}, 8'h01);
    rdc(8'h00, 8'h90);
    rst_i = 1'h1;
    tick(2);
    rst_i = 1'h0;
    tick(6);
    rdc(8'h00, 8'h90);
    $display("presence test done");
    give_verdict();
  end
  // long enough for all tests with wide margin
  initial begin
    #2400000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
